/* File: hw/eec_clk_div.sv */
// divider that paces the serial clock with one-cycle enables
`timescale 1ns/10ps
module eec_clk_div
	import eec_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	eec_tick_if.gen  tick
);
	logic [2:0] cnt_r;   // cycles within a half period
	logic       phase_r; // which half comes next

	// free running: the engine only looks at ticks while shifting, in the gap and in the poll
	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_r   <= 3'h0;
			phase_r <= 1'b0;
		end else if (cnt_r == EEC_HALF_LAST) begin
			cnt_r   <= 3'h0;
			phase_r <= ~phase_r;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end

	assign tick.rise = (cnt_r == EEC_HALF_LAST) && !phase_r;
	assign tick.fall = (cnt_r == EEC_HALF_LAST) && phase_r;
endmodule

/* File: hw/eec_ctrl.sv */
// command engine for a three-wire serial eeprom behind a register port
`timescale 1ns/10ps
// ********************************************************************
// serial eeprom command engine
// ********************************************************************
module eec_ctrl
	import eec_pkg::*;
#(
	parameter logic [20:0] TIMEOUT_CYCLES = EEC_TMO_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             rom_cs,
	output logic             rom_sclk,
	output logic             rom_sdo,
	input  wire logic        rom_serial_data_in
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,  // waiting for a command
		ST_SHIFT, // clocking the frame out and read data in
		ST_GAP,   // chip deselected before the ready poll
		ST_POLL,  // waiting for the eeprom to report ready
		ST_DONE   // one cycle to commit the result
	} eec_state_t;

	eec_state_t  state_r;     // engine state
	eec_op_t     op_r;        // opcode field as software wrote it
	eec_op_t     run_op_r;    // operation being carried out
	logic [8:0]  addr_r;      // byte address field
	logic [7:0]  data_r;      // data register byte
	logic        busy_r;      // busy flag
	logic        timeout_r;   // sticky timeout flag
	logic        load_done_r; // sticky load done flag
	logic        boot_r;      // power-up load still pending
	logic [19:0] frame_r;     // outgoing bits, msb first
	logic [4:0]  bit_cnt_r;   // rising edges still to come
	logic        bit_out_r;   // bit awaits its rise; in poll, line settling
	logic [7:0]  rx_r;        // bits sampled on rising edges
	logic [20:0] tmo_cnt_r;   // cycles spent busy
	logic        din_s;       // synchronised serial data in
	logic        cmd_wr;      // write to the command register
	logic        data_wr;     // write to the data register
	logic        start_req;   // software start of a command
	logic        go;          // a command begins this cycle
	eec_op_t     go_op;       // opcode of the starting command
	logic [8:0]  go_addr;     // address of the starting command
	logic        tmo_hit;     // the no-response limit is reached
	logic        poll_op;     // operation ends with a ready poll
	logic [31:0] rd_nxt;      // read data for the next cycle

	eec_tick_if tick ();

	// ****************************************************************
	// pacing and input synchronisation
	// ****************************************************************
	eec_clk_div u_div (
		.clock (clock),
		.reset (reset),
		.tick  (tick)
	);

	eec_sync2 u_sync (
		.clock (clock),
		.reset (reset),
		.d     (rom_serial_data_in),
		.q     (din_s)
	);

	// ****************************************************************
	// decode
	// ****************************************************************
	assign cmd_wr    = reg_wr && (reg_addr == EEC_CMD_OFF);
	assign data_wr   = reg_wr && (reg_addr == EEC_DATA_OFF);
	// a start while busy is dropped, the running command is kept
	assign start_req = cmd_wr && reg_wdata[EEC_BUSY_BIT] && !busy_r;
	// software wins over the pending power-up load
	assign go        = !busy_r && (start_req || boot_r);
	assign go_op     = start_req ?
		eec_op_t'(reg_wdata[EEC_OP_MSB:EEC_OP_LSB]) : EEC_OP_RELOAD;
	assign go_addr   = start_req ? reg_wdata[EEC_ADDR_MSB:0] : addr_r;
	assign tmo_hit   = busy_r && (tmo_cnt_r == TIMEOUT_CYCLES - 21'h1);
	// only these wait for ready, so only these can hang without a part
	assign poll_op   = (run_op_r == EEC_OP_WRITE) ||
		(run_op_r == EEC_OP_WRALL) || (run_op_r == EEC_OP_ERASE) ||
		(run_op_r == EEC_OP_ERALL);

	// ****************************************************************
	// software fields
	// ****************************************************************
	// software writes to the fields are ignored while busy so a running frame never changes
	always_ff @(posedge clock) begin
		if (reset) begin
			op_r   <= eec_op_t'(EEC_OP_RST);
			addr_r <= EEC_ADDR_RST;
			data_r <= EEC_DATA_RST;
		end else if (state_r == ST_DONE && run_op_r == EEC_OP_READ) begin
			data_r <= rx_r;
		end else if (cmd_wr && !busy_r) begin
			op_r   <= eec_op_t'(reg_wdata[EEC_OP_MSB:EEC_OP_LSB]);
			addr_r <= reg_wdata[EEC_ADDR_MSB:0];
		end else if (data_wr && !busy_r) begin
			data_r <= reg_wdata[EEC_DATA_MSB:0];
		end
	end

	// ****************************************************************
	// sticky flags, cleared by writing one; a set in the same cycle wins
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			timeout_r <= 1'b0;
		end else if (tmo_hit) begin
			timeout_r <= 1'b1;
		end else if (cmd_wr && reg_wdata[EEC_TO_BIT]) begin
			timeout_r <= 1'b0;
		end
	end

	// a failed reload touches nothing, this flag included
	always_ff @(posedge clock) begin
		if (reset) begin
			load_done_r <= 1'b0;
		end else if (state_r == ST_DONE && run_op_r == EEC_OP_RELOAD &&
			rx_r == EEC_SIG) begin
			load_done_r <= 1'b1;
		end else if (cmd_wr && reg_wdata[EEC_DL_BIT]) begin
			load_done_r <= 1'b0;
		end
	end

	// ****************************************************************
	// no-response timer
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset || go) begin
			tmo_cnt_r <= 21'h0_0000;
		end else if (busy_r) begin
			tmo_cnt_r <= tmo_cnt_r + 21'h0_0001;
		end
	end

	// ****************************************************************
	// command sequencer and serial pins
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			state_r   <= ST_IDLE;
			run_op_r  <= EEC_OP_READ;
			busy_r    <= 1'b0;
			boot_r    <= 1'b1;
			frame_r   <= 20'h0_0000;
			bit_cnt_r <= 5'h00;
			bit_out_r <= 1'b0;
			rx_r      <= 8'h00;
			rom_cs    <= 1'b0;
			rom_sclk  <= 1'b0;
			rom_sdo   <= 1'b0;
		end else if (tmo_hit) begin
			// give up: deselect and go back to idle
			state_r  <= ST_IDLE;
			busy_r   <= 1'b0;
			rom_cs   <= 1'b0;
			rom_sclk <= 1'b0;
			rom_sdo  <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (go) begin
						state_r   <= ST_SHIFT;
						run_op_r  <= go_op;
						busy_r    <= 1'b1;
						boot_r    <= 1'b0;
						bit_out_r <= 1'b0;
						rom_cs    <= 1'b1;
						unique case (go_op)
							EEC_OP_READ: begin
								frame_r   <= {1'b1, EEC_MW_READ, go_addr,
									8'h00};
								bit_cnt_r <= EEC_LEN_LONG;
							end
							EEC_OP_RELOAD: begin
								frame_r   <= {1'b1, EEC_MW_READ, 9'h000,
									8'h00};
								bit_cnt_r <= EEC_LEN_LONG;
							end
							EEC_OP_WRDIS: begin
								frame_r   <= {1'b1, EEC_MW_EXT, EEC_EX_WRDIS,
									15'h0000};
								bit_cnt_r <= EEC_LEN_SHORT;
							end
							EEC_OP_WREN: begin
								frame_r   <= {1'b1, EEC_MW_EXT, EEC_EX_WREN,
									15'h0000};
								bit_cnt_r <= EEC_LEN_SHORT;
							end
							EEC_OP_WRITE: begin
								frame_r   <= {1'b1, EEC_MW_WRITE, go_addr,
									data_r};
								bit_cnt_r <= EEC_LEN_LONG;
							end
							EEC_OP_WRALL: begin
								frame_r   <= {1'b1, EEC_MW_EXT, EEC_EX_WRALL,
									7'h00, data_r};
								bit_cnt_r <= EEC_LEN_LONG;
							end
							EEC_OP_ERASE: begin
								frame_r   <= {1'b1, EEC_MW_ERASE, go_addr,
									8'h00};
								bit_cnt_r <= EEC_LEN_SHORT;
							end
							EEC_OP_ERALL: begin
								frame_r   <= {1'b1, EEC_MW_EXT, EEC_EX_ERALL,
									15'h0000};
								bit_cnt_r <= EEC_LEN_SHORT;
							end
						endcase
					end
				end
				ST_SHIFT: begin
					if (tick.fall) begin
						rom_sclk <= 1'b0;
						if (bit_cnt_r == 5'h00) begin
							rom_sdo <= 1'b0; // frame over: deselect
							rom_cs  <= 1'b0;
							state_r <= poll_op ? ST_GAP : ST_DONE;
						end else begin
							// present the next bit, zeros once sent out
							rom_sdo   <= frame_r[19];
							frame_r   <= {frame_r[18:0], 1'b0};
							bit_out_r <= 1'b1;
						end
					end else if (tick.rise && bit_out_r) begin
						rom_sclk  <= 1'b1;
						bit_out_r <= 1'b0;
						rx_r      <= {rx_r[6:0], din_s};
						bit_cnt_r <= bit_cnt_r - 5'h01;
					end
				end
				ST_GAP: begin
					if (tick.fall) begin // one serial period deselected
						rom_cs    <= 1'b1;
						bit_out_r <= 1'b1; // synchronised line still stale
						state_r   <= ST_POLL;
					end
				end
				ST_POLL: begin
					// high is ready, also with no part on a pulled-up line, after one rise tick
					bit_out_r <= bit_out_r && !tick.rise;
					if (!bit_out_r && din_s) begin
						rom_cs  <= 1'b0;
						state_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					busy_r  <= 1'b0;
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// register read port, data one cycle after the strobe
	// ****************************************************************
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (reg_addr == EEC_CMD_OFF) begin
			rd_nxt[EEC_BUSY_BIT]           = busy_r;
			rd_nxt[EEC_OP_MSB:EEC_OP_LSB]  = op_r;
			rd_nxt[EEC_TO_BIT]             = timeout_r;
			rd_nxt[EEC_DL_BIT]             = load_done_r;
			rd_nxt[EEC_ADDR_MSB:0]         = addr_r;
		end else if (reg_addr == EEC_DATA_OFF) begin
			rd_nxt[EEC_DATA_MSB:0] = data_r;
		end
	end

	// unmapped addresses and idle cycles read as zero
	always_ff @(posedge clock) begin
		if (reset || !reg_rd) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= rd_nxt;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	start_busy_a: assert property (
		start_req && state_r == ST_IDLE |=> busy_r && state_r == ST_SHIFT)
		else $error("start did not raise busy");
	busy_pins_a: assert property (
		state_r == ST_IDLE |-> !rom_cs && !rom_sclk)
		else $error("serial pins active while idle");
	read_frame_a: assert property (
		go && go_op == EEC_OP_READ |=>
		frame_r[19:17] == {1'b1, EEC_MW_READ} && bit_cnt_r == EEC_LEN_LONG)
		else $error("read frame header wrong");
	read_data_a: assert property (
		state_r == ST_DONE && run_op_r == EEC_OP_READ |=>
		data_r == $past(rx_r) && !busy_r)
		else $error("read byte not stored");
	timeout_set_a: assert property (
		tmo_hit |=> timeout_r && !busy_r && !rom_cs)
		else $error("timeout not taken");
	timeout_hold_a: assert property (
		timeout_r && !(cmd_wr && reg_wdata[EEC_TO_BIT]) |=> timeout_r)
		else $error("timeout flag lost");
	reload_ok_a: assert property (
		$rose(load_done_r) |-> $past(run_op_r) == EEC_OP_RELOAD &&
		$past(rx_r) == EEC_SIG)
		else $error("load done without signature");
	reload_fail_a: assert property (
		state_r == ST_DONE && run_op_r == EEC_OP_RELOAD &&
		rx_r != EEC_SIG |=> $stable(load_done_r) && $stable(data_r))
		else $error("failed reload changed state");
	addr_freeze_a: assert property (
		busy_r && cmd_wr |=> $stable(addr_r) && $stable(op_r))
		else $error("fields changed while busy");
	poll_ready_a: assert property (
		state_r == ST_POLL && !bit_out_r && din_s && !tmo_hit |=>
		state_r == ST_DONE ##1 !busy_r)
		else $error("ready did not end command");
	no_poll_a: assert property (
		state_r == ST_SHIFT && !poll_op |-> ##[0:400] state_r != ST_SHIFT)
		else $error("non-write command overran");

	read_done_c: cover property (
		state_r == ST_DONE && run_op_r == EEC_OP_READ);
	write_poll_c: cover property (state_r == ST_POLL ##1 state_r == ST_DONE);
	timeout_c: cover property (tmo_hit);
	reload_ok_c: cover property ($rose(load_done_r));
endmodule

/* File: hw/eec_pkg.sv */
// shared constants and types of the serial eeprom command engine
package eec_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] EEC_CMD_OFF  = 8'h40; // command register
	localparam logic [7:0] EEC_DATA_OFF = 8'h44; // data register

	// command and data register field positions
	localparam int EEC_BUSY_BIT = 31;
	localparam int EEC_OP_MSB   = 30;
	localparam int EEC_OP_LSB   = 28;
	localparam int EEC_TO_BIT   = 10;
	localparam int EEC_DL_BIT   = 9;
	localparam int EEC_ADDR_MSB = 8;
	localparam int EEC_DATA_MSB = 7;

	// reset values
	localparam logic [2:0] EEC_OP_RST   = 3'h0;
	localparam logic [8:0] EEC_ADDR_RST = 9'h000;
	localparam logic [7:0] EEC_DATA_RST = 8'h00;

	// signature that marks a programmed eeprom at address zero
	localparam logic [7:0] EEC_SIG = 8'hA5;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int EEC_CLK_HZ  = 50_000_000; // system clock rate
	localparam int EEC_CLK_NS  = 20;         // system clock period
	localparam int EEC_TMO_MS  = 30;         // no-response limit
	localparam int EEC_SCLK_NS = 160;        // serial clock period
	// longest time: rounds down
	localparam logic [20:0] EEC_TMO_CYCLES =
		21'(EEC_CLK_HZ / 1000 * EEC_TMO_MS);
	// least half period: rounds up
	localparam int EEC_HALF_CYC =
		(EEC_SCLK_NS + 2 * EEC_CLK_NS - 1) / (2 * EEC_CLK_NS);
	localparam logic [2:0] EEC_HALF_LAST = 3'(EEC_HALF_CYC - 1);

	// ****************************************************************
	// serial frame: start bit, two opcode bits, nine address bits, data
	// ****************************************************************
	localparam logic [4:0] EEC_LEN_SHORT = 5'h0C; // start+op+address
	localparam logic [4:0] EEC_LEN_LONG  = 5'h14; // plus eight data bits
	localparam logic [1:0] EEC_MW_READ  = 2'h2;
	localparam logic [1:0] EEC_MW_WRITE = 2'h1;
	localparam logic [1:0] EEC_MW_ERASE = 2'h3;
	localparam logic [1:0] EEC_MW_EXT   = 2'h0; // extended group
	localparam logic [1:0] EEC_EX_WRDIS = 2'h0;
	localparam logic [1:0] EEC_EX_WRALL = 2'h1;
	localparam logic [1:0] EEC_EX_ERALL = 2'h2;
	localparam logic [1:0] EEC_EX_WREN  = 2'h3;

	// software opcodes
	typedef enum logic [2:0] {
		EEC_OP_READ   = 3'h0,
		EEC_OP_WRDIS  = 3'h1,
		EEC_OP_WREN   = 3'h2,
		EEC_OP_WRITE  = 3'h3,
		EEC_OP_WRALL  = 3'h4,
		EEC_OP_ERASE  = 3'h5,
		EEC_OP_ERALL  = 3'h6,
		EEC_OP_RELOAD = 3'h7
	} eec_op_t;

endpackage

/* File: hw/eec_sync2.sv */
// two-stage synchroniser for a pin from outside the clock domain
`timescale 1ns/10ps
module eec_sync2 (
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic d,
	output logic      q
);
	logic meta_r; // first stage, read only by the second

	// resets high: an open data pin idles pulled up
	always_ff @(posedge clock) begin
		if (reset) begin
			meta_r <= 1'b1;
			q      <= 1'b1;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

/* File: hw/eec_tick_if.sv */
// tick pulses from the serial clock divider to the command engine
`timescale 1ns/10ps
interface eec_tick_if;
	logic rise; // serial clock is due to go high
	logic fall; // serial clock is due to go low
	modport gen (output rise, output fall);
	modport sink (input rise, input fall);
endinterface

/* File: test/eec_ctrl_tb.sv */
// self-checking bench of the serial eeprom command engine
`timescale 1ns/10ps
module eec_ctrl_tb
	import eec_pkg::*;
;
	// ****************
	// signals and parts
	// ****************
	localparam int TMO = 2000; // short no-response limit keeps runs brief
	logic        clock;
	logic        reset;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        rom_cs;
	logic        rom_sclk;
	logic        rom_sdo;
	logic        rom_din;
	logic        present;   // eeprom fitted
	logic        pull;      // board pull on the data-in line
	logic [31:0] busy_ns;   // programming time of the eeprom
	logic        dl_exp;    // expected load done flag
	int          error_cnt = 0;
	int          samples_checked = 0;

	eec_ctrl #(.TIMEOUT_CYCLES(21'(TMO))) u_eec_ctrl (
		.clock(clock), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rom_cs(rom_cs), .rom_sclk(rom_sclk),
		.rom_sdo(rom_sdo), .rom_serial_data_in(rom_din));
	eec_rom_model u_eec_rom_model (
		.rom_cs(rom_cs), .rom_sclk(rom_sclk), .rom_sdo(rom_sdo),
		.present(present), .pull(pull), .busy_ns(busy_ns),
		.rom_din(rom_din));

	// 50 mhz system clock
	initial begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end

	// ****************
	// bus and checks
	// ****************
	task automatic reg_wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic reg_rd32(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clock);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// array contents are judged straight from the model
	task automatic chk_mem(input logic [8:0] a, input logic [7:0] exp);
		chk({24'h0, u_eec_rom_model.mem[a]}, {24'h0, exp});
	endtask

	// poll until busy drops, bounded so a hang shows as a mismatch
	task automatic wait_idle(output logic [31:0] d);
		int n;
		n = 0;
		reg_rd32(EEC_CMD_OFF, d);
		while (d[31] !== 1'h0 && n < 5000) begin
			reg_rd32(EEC_CMD_OFF, d);
			n++;
		end
	endtask

	// clear both flags by writing ones; op and address go to zero
	task automatic clr_flags();
		logic [31:0] d;
		reg_wr32(EEC_CMD_OFF, 32'h0000_0600);
		dl_exp = 1'h0;
		reg_rd32(EEC_CMD_OFF, d);
		chk(d, 32'h0);
	endtask

	task automatic run_cmd(input logic [2:0] op, input logic [8:0] a,
		input logic tmo);
		logic [31:0] d;
		time         t0;
		reg_wr32(EEC_CMD_OFF, {1'h1, op, 19'h0, a});
		t0 = $time;
		reg_rd32(EEC_CMD_OFF, d);
		chk({31'h0, d[31]}, 32'h1);
		wait_idle(d);
		chk(d, {1'h0, op, 17'h0, tmo, dl_exp, a});
		if (tmo)
			chk({31'h0, $time - t0 >= 20 * (TMO - 20) &&
				$time - t0 <= 20 * (TMO + 20)}, 32'h1);
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ****************
	// tests
	// ****************
	initial begin
		logic [31:0] d;
		logic [8:0]  a;
		logic [7:0]  b;
		reset = 1'h1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		present = 1'h1;
		pull = 1'h1;
		busy_ns = 32'h190;
		dl_exp = 1'h1;
		void'($urandom(32'h550c));
		for (int i = 0; i < 512; i++)
			u_eec_rom_model.mem[i] = 8'($urandom);
		u_eec_rom_model.mem[0] = EEC_SIG;
		repeat (4) @(posedge clock);
		reset <= 1'h0;
		// power-up load finds the signature; stray writes go nowhere
		wait_idle(d);
		chk(d, 32'h0000_0200);
		reg_wr32(8'h48, 32'hffff_ffff);
		reg_rd32(8'h48, d);
		chk(d, 32'h0);
		clr_flags();
		$display("power-up test done");
		// reads, including both ends of the address range
		for (int i = 0; i < 6; i++) begin
			a = i == 0 ? 9'h1ff : i == 1 ? 9'h000 : 9'($urandom);
			run_cmd(EEC_OP_READ, a, 1'h0);
			reg_rd32(EEC_DATA_OFF, d);
			chk(d, {24'h0, u_eec_rom_model.mem[a]});
		end
		$display("read test done");
		// a write before enabling leaves the array alone
		a = 9'($urandom);
		b = ~u_eec_rom_model.mem[a];
		reg_wr32(EEC_DATA_OFF, {24'hff_ffff, b});
		reg_rd32(EEC_DATA_OFF, d);
		chk(d, {24'h0, b});
		run_cmd(EEC_OP_WRITE, a, 1'h0);
		chk_mem(a, ~b);
		run_cmd(EEC_OP_WREN, 9'h000, 1'h0);
		for (int i = 0; i < 4; i++) begin
			a = 9'($urandom);
			b = 8'($urandom);
			busy_ns <= 32'(200 + $urandom % 20000);
			reg_wr32(EEC_DATA_OFF, {24'h0, b});
			run_cmd(EEC_OP_WRITE, a, 1'h0);
			chk_mem(a, b);
		end
		run_cmd(EEC_OP_ERASE, a, 1'h0);
		chk_mem(a, 8'hff);
		b = 8'($urandom);
		reg_wr32(EEC_DATA_OFF, {24'h0, b});
		run_cmd(EEC_OP_WRALL, 9'($urandom), 1'h0);
		chk_mem(9'h000, b);
		chk_mem(9'h1ff, b);
		run_cmd(EEC_OP_ERALL, 9'h000, 1'h0);
		chk_mem(9'h100, 8'hff);
		run_cmd(EEC_OP_WRDIS, 9'h000, 1'h0);
		reg_wr32(EEC_DATA_OFF, 32'h0000_003c);
		run_cmd(EEC_OP_WRITE, a, 1'h0);
		chk_mem(a, 8'hff);
		$display("program test done");
		// reload passes on the signature and fails without it
		u_eec_rom_model.mem[0] = EEC_SIG;
		dl_exp = 1'h1;
		run_cmd(EEC_OP_RELOAD, 9'h000, 1'h0);
		clr_flags();
		u_eec_rom_model.mem[0] = 8'h5a;
		reg_wr32(EEC_DATA_OFF, 32'h0000_0077);
		run_cmd(EEC_OP_RELOAD, 9'h000, 1'h0);
		reg_rd32(EEC_DATA_OFF, d);
		chk(d, 32'h0000_0077);
		$display("reload test done");
		// no part: every code with the line pulled low, then high
		present <= 1'h0;
		for (int p = 0; p < 2; p++) begin
			pull <= p[0];
			for (int k = 0; k < 8; k++) begin
				run_cmd(3'(k), 9'($urandom), p == 0 && k >= 3 && k <= 6);
				if (p == 0 && k >= 3 && k <= 6)
					clr_flags();
			end
		end
		$display("absent part test done");
		wrap_up();
	end

	// watchdog: about four times what the tests need
	initial begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		wrap_up();
	end
endmodule

/* File: test/eec_rom_model.sv */
// behavioural three-wire serial eeprom facing the command engine
`timescale 1ns/10ps
module eec_rom_model (
	input  wire logic        rom_cs,
	input  wire logic        rom_sclk,
	input  wire logic        rom_sdo,
	input  wire logic        present,
	input  wire logic        pull,
	input  wire logic [31:0] busy_ns,
	output logic             rom_din
);
	// ****************
	// array and frame
	// ****************
	logic [7:0]  mem [512]; // contents, filled by the bench
	logic [19:0] sh;        // bits since the start bit
	logic [1:0]  op;        // opcode bits of the frame
	logic [8:0]  adr;       // address bits of the frame
	int          n = 0;     // bits taken, start bit included
	bit          wen = 0;   // erase/write enable, off at power-up
	bit          busy = 0;  // programming cycle running
	bit          stat = 0;  // status phase after a program frame
	bit          drv = 0;   // read data on the line
	logic        dout;      // read data bit
	logic        pw;        // frame asks for programming

	// a released line floats to the pull, so stale data never shows
	assign rom_din = (!present || !rom_cs) ? pull :
		drv ? dout : stat ? !busy : pull;

	// shift in on the rising serial clock; leading zeros are skipped
	always @(posedge rom_sclk) begin
		if (rom_cs && present && (n > 0 || rom_sdo)) begin
			sh = {sh[18:0], rom_sdo};
			n = n + 1;
			stat = 1'h0;
			if (n == 12) begin
				op = sh[10:9];
				adr = sh[8:0];
			end
		end
	end

	// read data leaves msb first after the twelfth clock
	always @(negedge rom_sclk) begin
		drv = rom_cs && op == 2'h2 && n >= 12 && n < 20;
		dout = mem[adr][19 - n];
	end

	// frame end: carry out what was clocked in
	always @(negedge rom_cs) begin
		drv = 1'h0;
		pw = (n == 20 && op[1] == 1'h0) ||
			(n == 12 && (op == 2'h3 || (op == 2'h0 && adr[8:7] == 2'h2)));
		if (wen && n == 20 && op == 2'h1)
			mem[adr] = sh[7:0];
		for (int i = 0; i < 512; i++) begin
			if (wen && n == 20 && op == 2'h0)
				mem[i] = sh[7:0];
			if (wen && n == 12 && op == 2'h0 && adr[8:7] == 2'h2)
				mem[i] = 8'hff;
		end
		if (wen && n == 12 && op == 2'h3)
			mem[adr] = 8'hff;
		if (n == 12 && op == 2'h0 && adr[8:7] == 2'h3)
			wen = 1'h1;
		if (n == 12 && op == 2'h0 && adr[8:7] == 2'h0)
			wen = 1'h0;
		stat = pw;
		busy = pw && wen;
		n = 0;
	end

	// the programming cycle lasts as long as the bench chose
	always @(posedge busy)
		busy <= #(busy_ns) 1'h0;
endmodule
